// File: logic/sdram_cmd_consts.svh
// Timing counts and field positions of the two-bank DRAM command block.
// Included by the package users; holds definitions only.
`ifndef SDRAM_CMD_CONSTS_SVH
`define SDRAM_CMD_CONSTS_SVH
`define CLK_PERIOD_NS          10
`define ROW_CLOSE_NS           30
`define ROW_TO_COLUMN_DELAY_NS 30
`define BANK_TO_BANK_OPEN_SPACING_NS 20
`define ROW_ACTIVE_MIN_NS      60
`define WRITE_RECOVERY_TIME_CYC 2
`define DATA_IN_TO_IDLE_TIME_CYC 5
`define MODE_LOAD_TO_COMMAND_DELAY_CYC 2
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BANK_SEL_BIT           11
`define AUTOCLOSE_BIT          10
`define BURST_LEN_LSB          0
`define BURST_LEN_FULL_PAGE    3'h7
`define MODE_RESET_VAL         12'h000
`define ADDR_W                 12
`define DATA_W                 16
`endif

// File: logic/sdram_cmd_pkg.sv
// Types shared by both ends of the DRAM command link.
// Assumes the constants header is compiled alongside.
package sdram_cmd_pkg;
	typedef enum logic [3:0] {
		chip_unselected_cmd, no_action_cmd, burst_halt_cmd, read_cmd,
		write_cmd, row_open_cmd, bank_close_cmd, refresh_cmd, config_load_cmd
	} cmd_t;
	typedef enum {
		st_idle, st_row_opening, st_active, st_read, st_write, st_write_autoclose,
		st_write_recovery, st_write_recovery_autoclose, st_row_closing
	} bank_state_t;
	typedef enum {
		gs_normal, gs_refresh, gs_mode_load, gs_power_down, gs_self_retention
	} global_state_t;
endpackage

// File: logic/sdram_link_if.sv
// Command pins between the memory controller and the DRAM.
// Both ends share mclk; no tristate pins here.
`timescale 1ns/10ps
`include "sdram_cmd_consts.svh"
interface sdram_link_if;
	logic                 cke;
	logic                 cs_n;
	logic                 ras_n;
	logic                 cas_n;
	logic                 we_n;
	logic [`ADDR_W-1:0]   addr;
	logic [`DATA_W-1:0]   dq_wr;
	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr, dq_wr);
	modport dram (input cke, cs_n, ras_n, cas_n, we_n, addr, dq_wr);
endinterface

// File: logic/word_buffer2.sv
// Two-entry valid/ready buffer for request words.
// Assumes one clock and the shared async reset.
`timescale 1ns/10ps
module word_buffer2 #(
	parameter int W = 16
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0]        cnt;
	} buf_t;
	buf_t s_q, s_d;
	logic push;
	logic pop;
	assign in_ready  = (s_q.cnt != 2'h2);
	assign out_valid = (s_q.cnt != 2'h0);
	assign out_data  = s_q.mem[0];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always_comb begin
		s_d = s_q;
		if (pop) begin
			s_d.mem[0] = s_q.mem[1];
		end
		if (push) begin
			if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
				s_d.mem[0] = in_data;
			end else begin
				s_d.mem[1] = in_data;
			end
		end
		s_d.cnt = 2'(s_q.cnt + {1'b0, push} - {1'b0, pop});
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule

// File: logic/sdram_cmd_dram.sv
// DRAM end: decodes commands and tracks both banks' transient states.
// Assumes the controller keeps the timing and legality it owes.
`timescale 1ns/10ps
`include "sdram_cmd_consts.svh"
// Contract
// (R1) Decode command from select and strobes
// (R2) Sample every input on rising edge only
// (R3) Autoclose write continues, then recovers, closes
// (R4) Bank-dependent commands only to other bank
// (R5) Row closing: no-ops, idle after close period
// (R6) Row opening: active after row-to-column delay
// (R7) Other bank open needs bank spacing
// (R8) Write recovery: active after time; read/write start
// (R9) Recovery autoclose: idle after data-in time
// (R10) Refresh: no-ops, idle after close period
// (R11) Mode load: idle after load delay
// (R12) Mode load stores address bits as opcode
// (R13) Refresh ignores address and data pins
// (R14) Self-retention ignores all but clock enable
// (R15) Global-idle commands need both banks idle
// (R16) Row open needs idle bank
// (R17) Read/write need active bank
// (R18) Burst halt only with full page
// (R19) Idle plus enable low enters power-down
// (R20) Refresh with enable low enters self-retention
// (R21) Close needs row-active minimum time
// (R22) Autoclose burst ends in closed state
module sdram_cmd_dram #(
	parameter int BURST_MAX = 256
) (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst,
	// Link from controller
	sdram_link_if.dram                 link,
	// Status
	output logic [1:0]                 bank_active,
	output logic [1:0]                 bank_idle,
	output logic [`ADDR_W-1:0]         mode_word,
	output logic                       powered_down,
	output logic                       self_retention,
	output logic                       illegal_cmd,
	output logic                       wr_word_valid,
	output logic [`DATA_W-1:0]         wr_word
);
	localparam int ROW_CLOSE_CYC = `CEIL_CYC(`ROW_CLOSE_NS);
	localparam int RCD_CYC       = `CEIL_CYC(`ROW_TO_COLUMN_DELAY_NS);
	localparam int CW            = 9;

	typedef struct packed {
		sdram_cmd_pkg::bank_state_t [1:0] st;
		logic [1:0][CW-1:0]               cnt;
		sdram_cmd_pkg::global_state_t     gs;
		logic [CW-1:0]                    gcnt;
		logic [`ADDR_W-1:0]               mode;
		logic [1:0]                       act;
		logic [1:0]                       idl;
		logic                             pd;
		logic                             sr;
		logic                             ill;
		logic                             wv;
		logic [`DATA_W-1:0]               wd;
	} dram_t;
	dram_t s_q, s_d;

	// (R1) strobe decode
	function automatic sdram_cmd_pkg::cmd_t decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		if (cs_n) begin
			return sdram_cmd_pkg::chip_unselected_cmd;
		end
		case ({ras_n, cas_n, we_n})
			3'h7: return sdram_cmd_pkg::no_action_cmd;
			3'h6: return sdram_cmd_pkg::burst_halt_cmd;
			3'h5: return sdram_cmd_pkg::read_cmd;
			3'h4: return sdram_cmd_pkg::write_cmd;
			3'h3: return sdram_cmd_pkg::row_open_cmd;
			3'h2: return sdram_cmd_pkg::bank_close_cmd;
			3'h1: return sdram_cmd_pkg::refresh_cmd;
			default: return sdram_cmd_pkg::config_load_cmd;
		endcase
	endfunction

	function automatic logic [CW-1:0] burst_len(input logic [`ADDR_W-1:0] m);
		case (m[`BURST_LEN_LSB +: 3])
			3'h0: return CW'(1);
			3'h1: return CW'(2);
			3'h2: return CW'(4);
			3'h3: return CW'(8);
			default: return CW'(BURST_MAX);
		endcase
	endfunction

	sdram_cmd_pkg::cmd_t cmd;
	logic                bsel;
	logic                ac;
	logic                both_idle;
	logic                full_page;

	assign cmd       = decode(link.cs_n, link.ras_n, link.cas_n, link.we_n);
	assign bsel      = link.addr[`BANK_SEL_BIT];
	assign ac        = link.addr[`AUTOCLOSE_BIT];
	assign both_idle = (s_q.st[0] == sdram_cmd_pkg::st_idle) &&
		(s_q.st[1] == sdram_cmd_pkg::st_idle) && (s_q.gs == sdram_cmd_pkg::gs_normal);
	assign full_page = (s_q.mode[`BURST_LEN_LSB +: 3] == `BURST_LEN_FULL_PAGE);

	always_comb begin
		s_d     = s_q;
		s_d.ill = 1'b0;
		s_d.wv  = 1'b0;
		for (int b = 0; b < 2; b++) begin
			if (s_q.cnt[b] != '0) begin
				s_d.cnt[b] = CW'(s_q.cnt[b] - 1'b1);
			end
		end
		if (s_q.gcnt != '0) begin
			s_d.gcnt = CW'(s_q.gcnt - 1'b1);
		end
		// Per-bank timed transitions
		for (int b = 0; b < 2; b++) begin
			if (s_q.cnt[b] == CW'(1) || s_q.cnt[b] == '0) begin
				case (s_q.st[b])
					// (R5) close period over
					sdram_cmd_pkg::st_row_closing: s_d.st[b] = sdram_cmd_pkg::st_idle;
					// (R6) row-to-column delay over
					sdram_cmd_pkg::st_row_opening: s_d.st[b] = sdram_cmd_pkg::st_active;
					sdram_cmd_pkg::st_read: s_d.st[b] = sdram_cmd_pkg::st_active;
					sdram_cmd_pkg::st_write: begin
						s_d.st[b]  = sdram_cmd_pkg::st_write_recovery;
						s_d.cnt[b] = CW'(`WRITE_RECOVERY_TIME_CYC);
					end
					// (R3) burst done, recover then close
					sdram_cmd_pkg::st_write_autoclose: begin
						s_d.st[b]  = sdram_cmd_pkg::st_write_recovery_autoclose;
						s_d.cnt[b] = CW'(`DATA_IN_TO_IDLE_TIME_CYC);
					end
					// (R8) recovery time over
					sdram_cmd_pkg::st_write_recovery: s_d.st[b] = sdram_cmd_pkg::st_active;
					// (R9) (R22) closed without command
					sdram_cmd_pkg::st_write_recovery_autoclose:
						s_d.st[b] = sdram_cmd_pkg::st_idle;
					default: ;
				endcase
			end
		end
		// (R10) (R11) global interval done
		if ((s_q.gs == sdram_cmd_pkg::gs_refresh || s_q.gs == sdram_cmd_pkg::gs_mode_load)
			&& s_q.gcnt <= CW'(1)) begin
			s_d.gs = sdram_cmd_pkg::gs_normal;
		end
		// (R14) (R19) only enable is watched while asleep
		if (s_q.gs == sdram_cmd_pkg::gs_power_down || s_q.gs == sdram_cmd_pkg::gs_self_retention) begin
			if (link.cke) begin
				s_d.gs   = (s_q.gs == sdram_cmd_pkg::gs_self_retention) ?
					sdram_cmd_pkg::gs_refresh : sdram_cmd_pkg::gs_normal;
				s_d.gcnt = CW'(ROW_CLOSE_CYC);
			end
		end else if (s_q.gs != sdram_cmd_pkg::gs_normal) begin
			// (R10) (R11) anything but deselect, no-op or burst halt is illegal
			if (cmd != sdram_cmd_pkg::chip_unselected_cmd && cmd != sdram_cmd_pkg::no_action_cmd
				&& cmd != sdram_cmd_pkg::burst_halt_cmd) begin
				s_d.ill = 1'b1;
			end
		end else if (both_idle && !link.cke && cmd != sdram_cmd_pkg::refresh_cmd) begin
			// (R19) power-down entry
			s_d.gs = sdram_cmd_pkg::gs_power_down;
		end else begin
			case (cmd)
				sdram_cmd_pkg::refresh_cmd: begin
					// (R15) (R13) (R20) address and data not used
					if (!both_idle) begin
						s_d.ill = 1'b1;
					end else if (!link.cke) begin
						s_d.gs = sdram_cmd_pkg::gs_self_retention;
					end else begin
						s_d.gs   = sdram_cmd_pkg::gs_refresh;
						s_d.gcnt = CW'(ROW_CLOSE_CYC);
					end
				end
				sdram_cmd_pkg::config_load_cmd: begin
					// (R15) (R12) opcode capture
					if (!both_idle) begin
						s_d.ill = 1'b1;
					end else begin
						s_d.mode = link.addr;
						s_d.gs   = sdram_cmd_pkg::gs_mode_load;
						s_d.gcnt = CW'(`MODE_LOAD_TO_COMMAND_DELAY_CYC);
					end
				end
				sdram_cmd_pkg::row_open_cmd: begin
					// (R16) (R4) addressed bank only
					if (s_q.st[bsel] != sdram_cmd_pkg::st_idle) begin
						s_d.ill = 1'b1;
					end else begin
						s_d.st[bsel]  = sdram_cmd_pkg::st_row_opening;
						s_d.cnt[bsel] = CW'(RCD_CYC);
					end
				end
				sdram_cmd_pkg::read_cmd, sdram_cmd_pkg::write_cmd: begin
					// (R17) (R8) active or recovering row
					if (s_q.st[bsel] == sdram_cmd_pkg::st_active ||
						s_q.st[bsel] == sdram_cmd_pkg::st_read ||
						s_q.st[bsel] == sdram_cmd_pkg::st_write ||
						s_q.st[bsel] == sdram_cmd_pkg::st_write_recovery) begin
						s_d.cnt[bsel] = burst_len(s_q.mode);
						if (cmd == sdram_cmd_pkg::read_cmd) begin
							s_d.st[bsel] = sdram_cmd_pkg::st_read;
						end else begin
							s_d.st[bsel] = ac ? sdram_cmd_pkg::st_write_autoclose :
								sdram_cmd_pkg::st_write;
							s_d.wv = 1'b1;
							s_d.wd = link.dq_wr;
						end
						// (R22) read with autoclose closes after burst
						if (cmd == sdram_cmd_pkg::read_cmd && ac) begin
							s_d.st[bsel]  = sdram_cmd_pkg::st_row_closing;
							s_d.cnt[bsel] = CW'(burst_len(s_q.mode) + CW'(ROW_CLOSE_CYC));
						end
					end else begin
						s_d.ill = 1'b1;
					end
				end
				sdram_cmd_pkg::bank_close_cmd: begin
					// (R5) (R21) close active rows; closing again is a no-op
					for (int b = 0; b < 2; b++) begin
						if ((ac || bsel == 1'(b)) && (s_q.st[b] == sdram_cmd_pkg::st_active ||
							s_q.st[b] == sdram_cmd_pkg::st_read ||
							s_q.st[b] == sdram_cmd_pkg::st_write)) begin
							s_d.st[b]  = sdram_cmd_pkg::st_row_closing;
							s_d.cnt[b] = CW'(ROW_CLOSE_CYC);
						end
					end
				end
				sdram_cmd_pkg::burst_halt_cmd: begin
					// (R18) halts only a full-page burst
					for (int b = 0; b < 2; b++) begin
						if (full_page && (s_q.st[b] == sdram_cmd_pkg::st_read ||
							s_q.st[b] == sdram_cmd_pkg::st_write)) begin
							s_d.st[b]  = sdram_cmd_pkg::st_active;
							s_d.cnt[b] = '0;
						end
					end
				end
				default: ;
			endcase
		end
		s_d.pd  = (s_d.gs == sdram_cmd_pkg::gs_power_down);
		s_d.sr  = (s_d.gs == sdram_cmd_pkg::gs_self_retention);
		for (int b = 0; b < 2; b++) begin
			s_d.act[b] = (s_d.st[b] == sdram_cmd_pkg::st_active);
			s_d.idl[b] = (s_d.st[b] == sdram_cmd_pkg::st_idle);
		end
	end

	// (R2) all sampling on the rising edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q      <= '0;
			s_q.mode <= `MODE_RESET_VAL;
			s_q.idl  <= 2'h3;
		end else begin
			s_q <= s_d;
		end
	end

	assign bank_active    = s_q.act;
	assign bank_idle      = s_q.idl;
	assign mode_word      = s_q.mode;
	assign powered_down   = s_q.pd;
	assign self_retention = s_q.sr;
	assign illegal_cmd    = s_q.ill;
	assign wr_word_valid  = s_q.wv;
	assign wr_word        = s_q.wd;
endmodule

// File: logic/sdram_cmd_ctrl.sv
// Controller end: drives one command per request onto the link.
// Buffers requests two deep; holds off until spacing rules are met.
`timescale 1ns/10ps
`include "sdram_cmd_consts.svh"
module sdram_cmd_ctrl (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rst,
	// Request side: {cke, cmd code[3:0], addr, data}
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire logic [3:0]            req_cmd,
	input  wire logic                  req_cke,
	input  wire logic [`ADDR_W-1:0]    req_addr,
	input  wire logic [`DATA_W-1:0]    req_data,
	// Link to the DRAM
	sdram_link_if.ctrl                 link
);
	localparam int RW  = 1 + 4 + `ADDR_W + `DATA_W;
	localparam int RRD = `CEIL_CYC(`BANK_TO_BANK_OPEN_SPACING_NS);
	localparam int RAS = `CEIL_CYC(`ROW_ACTIVE_MIN_NS);

	typedef struct packed {
		logic [3:0]         wait_cnt;
		logic [1:0][3:0]    ras_cnt;
		logic               cke;
		logic [3:0]         strobes;
		logic [`ADDR_W-1:0] addr;
		logic [`DATA_W-1:0] dq;
	} ctrl_t;
	ctrl_t s_q, s_d;

	logic          b_valid;
	logic          b_ready;
	logic [RW-1:0] b_data;
	sdram_cmd_pkg::cmd_t c;
	logic          bs;
	logic          ab;

	word_buffer2 #(.W(RW)) word_buffer2_inst (
		.mclk      (mclk),
		.rst       (rst),
		.in_valid  (req_valid),
		.in_ready  (req_ready),
		.in_data   ({req_cke, req_cmd, req_addr, req_data}),
		.out_valid (b_valid),
		.out_ready (b_ready),
		.out_data  (b_data)
	);

	assign c  = sdram_cmd_pkg::cmd_t'(b_data[RW-2 -: 4]);
	assign bs = b_data[`DATA_W + `BANK_SEL_BIT];
	assign ab = b_data[`DATA_W + `AUTOCLOSE_BIT];
	// (R7) (R21) stall until spacing is met; an all-bank close waits for both
	assign b_ready = (s_q.wait_cnt == '0) &&
		!(c == sdram_cmd_pkg::bank_close_cmd && (s_q.ras_cnt[bs] != '0 ||
		(ab && s_q.ras_cnt != '0)));

	always_comb begin
		s_d = s_q;
		for (int b = 0; b < 2; b++) begin
			if (s_q.ras_cnt[b] != '0) begin
				s_d.ras_cnt[b] = 4'(s_q.ras_cnt[b] - 1'b1);
			end
		end
		if (s_q.wait_cnt != '0) begin
			s_d.wait_cnt = 4'(s_q.wait_cnt - 1'b1);
		end
		s_d.strobes = 4'hF;
		if (b_valid && b_ready) begin
			s_d.cke = b_data[RW-1];
			// Deselect keeps the address and data pins still
			if (c != sdram_cmd_pkg::chip_unselected_cmd) begin
				s_d.addr = b_data[`DATA_W +: `ADDR_W];
				s_d.dq   = b_data[`DATA_W-1:0];
			end
			// (R1) encode cs_n, ras_n, cas_n, we_n
			case (c)
				sdram_cmd_pkg::no_action_cmd:   s_d.strobes = 4'h7;
				sdram_cmd_pkg::burst_halt_cmd:  s_d.strobes = 4'h6;
				sdram_cmd_pkg::read_cmd:        s_d.strobes = 4'h5;
				sdram_cmd_pkg::write_cmd:       s_d.strobes = 4'h4;
				sdram_cmd_pkg::row_open_cmd:    s_d.strobes = 4'h3;
				sdram_cmd_pkg::bank_close_cmd:  s_d.strobes = 4'h2;
				sdram_cmd_pkg::refresh_cmd:     s_d.strobes = 4'h1;
				sdram_cmd_pkg::config_load_cmd: s_d.strobes = 4'h0;
				default:                        s_d.strobes = 4'hF;
			endcase
			if (c == sdram_cmd_pkg::row_open_cmd) begin
				// (R7) open spacing
				s_d.wait_cnt    = 4'(RRD);
				// (R21) row-active minimum
				s_d.ras_cnt[bs] = 4'(RAS);
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			s_q         <= '0;
			s_q.cke     <= 1'b1;
			s_q.strobes <= 4'hF;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.cke   = s_q.cke;
	assign link.cs_n  = s_q.strobes[3];
	assign link.ras_n = s_q.strobes[2];
	assign link.cas_n = s_q.strobes[1];
	assign link.we_n  = s_q.strobes[0];
	assign link.addr  = s_q.addr;
	assign link.dq_wr = s_q.dq;
endmodule

// File: verif/sdram_link_assertions.sv
// Concurrent checks on the command link between controller and DRAM.
// Assumes instantiation beside the link interface, on mclk with async rst.
`timescale 1ns/10ps
`include "sdram_cmd_consts.svh"
module sdram_link_assertions (
	// Clock and reset
	input  wire logic               mclk,
	input  wire logic               rst,
	// Link pins
	input  wire logic               cke,
	input  wire logic               cs_n,
	input  wire logic               ras_n,
	input  wire logic               cas_n,
	input  wire logic               we_n,
	input  wire logic [`ADDR_W-1:0] addr,
	input  wire logic [`DATA_W-1:0] dq_wr
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	wire open_c  = !cs_n && !ras_n && cas_n && we_n;
	wire close_c = !cs_n && !ras_n && cas_n && !we_n;
	// All-bank close hits both banks
	wire open0   = open_c && !addr[`BANK_SEL_BIT];
	wire open1   = open_c && addr[`BANK_SEL_BIT];
	wire close0  = close_c && (addr[`AUTOCLOSE_BIT] || !addr[`BANK_SEL_BIT]);
	wire close1  = close_c && (addr[`AUTOCLOSE_BIT] || addr[`BANK_SEL_BIT]);

	sequence open_then_hold(logic op, logic cl);
		op ##1 (!cl) [*5];
	endsequence
	sequence open_then_gap;
		open_c ##1 !open_c;
	endsequence
	property ras_gap(logic op, logic cl);
		op |-> open_then_hold(op, cl);
	endproperty

	AST_IDLE_AFTER_RST: assert property ($past(rst) |-> cs_n && cke)
		else $error("link not idle after reset");
	AST_DESEL_STROBES: assert property (cs_n |-> ras_n && cas_n && we_n)
		else $error("strobes low while deselected");
	AST_OPEN_SPACING: assert property (open_c |-> open_then_gap)
		else $error("row opens closer than bank spacing");
	AST_RAS_BANK0: assert property (ras_gap(open0, close0))
		else $error("bank 0 closed before row-active time");
	AST_RAS_BANK1: assert property (ras_gap(open1, close1))
		else $error("bank 1 closed before row-active time");
	AST_ADDR_HOLD: assert property (!$stable(addr) |-> !cs_n)
		else $error("address moved without a command");
	AST_DATA_HOLD: assert property (!$stable(dq_wr) |-> !cs_n)
		else $error("write data moved without a command");
endmodule

// File: verif/sdram_bank_command_state_logic_tb.sv
// Testbench joining controller and DRAM ends through the link interface.
// Assumes the design's package, header and modules are compiled first.
`timescale 1ns/10ps
`include "sdram_cmd_consts.svh"
module sdram_bank_command_state_logic_tb;
	localparam logic [3:0] C_UNSEL = sdram_cmd_pkg::chip_unselected_cmd;
	localparam logic [3:0] C_NOACT = sdram_cmd_pkg::no_action_cmd;
	localparam logic [3:0] C_HALT  = sdram_cmd_pkg::burst_halt_cmd;
	localparam logic [3:0] C_READ  = sdram_cmd_pkg::read_cmd;
	localparam logic [3:0] C_WRITE = sdram_cmd_pkg::write_cmd;
	localparam logic [3:0] C_OPEN  = sdram_cmd_pkg::row_open_cmd;
	localparam logic [3:0] C_CLOSE = sdram_cmd_pkg::bank_close_cmd;
	localparam logic [3:0] C_REFR  = sdram_cmd_pkg::refresh_cmd;
	localparam logic [3:0] C_LOAD  = sdram_cmd_pkg::config_load_cmd;

	logic               mclk      = 1'b0;
	logic               rst       = 1'b1;
	logic               req_valid = 1'b0;
	logic               req_ready;
	logic [3:0]         req_cmd   = 4'h0;
	logic               req_cke   = 1'b1;
	logic [`ADDR_W-1:0] req_addr  = 12'h000;
	logic [`DATA_W-1:0] req_data  = 16'h0000;
	logic [1:0]         bank_active;
	logic [1:0]         bank_idle;
	logic [`ADDR_W-1:0] mode_word;
	logic               powered_down;
	logic               self_retention;
	logic               illegal_cmd;
	logic               wr_word_valid;
	logic [`DATA_W-1:0] wr_word;
	logic [`DATA_W-1:0] last_wr   = 16'h0000;
	logic               refused   = 1'b0;
	int                 mismatches = 0;
	int                 compares  = 0;
	int                 illegals  = 0;
	int                 base;

	sdram_link_if sdram_link_if_inst ();
	sdram_cmd_ctrl sdram_cmd_ctrl_inst (.mclk(mclk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req_cmd(req_cmd), .req_cke(req_cke), .req_addr(req_addr),
		.req_data(req_data), .link(sdram_link_if_inst.ctrl));
	sdram_cmd_dram sdram_cmd_dram_inst (.mclk(mclk), .rst(rst), .link(sdram_link_if_inst.dram),
		.bank_active(bank_active), .bank_idle(bank_idle), .mode_word(mode_word),
		.powered_down(powered_down), .self_retention(self_retention),
		.illegal_cmd(illegal_cmd), .wr_word_valid(wr_word_valid), .wr_word(wr_word));
	sdram_link_assertions sdram_link_assertions_inst (.mclk(mclk), .rst(rst),
		.cke(sdram_link_if_inst.cke), .cs_n(sdram_link_if_inst.cs_n),
		.ras_n(sdram_link_if_inst.ras_n), .cas_n(sdram_link_if_inst.cas_n),
		.we_n(sdram_link_if_inst.we_n), .addr(sdram_link_if_inst.addr),
		.dq_wr(sdram_link_if_inst.dq_wr));

	always #5 mclk = ~mclk;

	// Pulses stand one cycle, so they are counted or latched here
	always @(posedge mclk) begin
		if (illegal_cmd === 1'b1)
			illegals++;
		if (wr_word_valid === 1'b1)
			last_wr <= wr_word;
	end

	task automatic end_sim();
		if (mismatches == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Deselect keeps address and data, so the link holds them
	task automatic issue(input logic [3:0] c, input logic k, input logic [11:0] a,
			input logic [15:0] d);
		logic r;
		int   i;
		@(posedge mclk);
		req_valid <= 1'b1;
		req_cmd   <= c;
		req_cke   <= k;
		if (c != C_UNSEL) begin
			req_addr <= a;
			req_data <= d;
		end
		for (i = 0; i < 50; i++) begin
			@(negedge mclk);
			r = req_ready;
			@(posedge mclk);
			if (r === 1'b1)
				break;
			refused = 1'b1;
		end
		req_valid <= 1'b0;
		if (i == 50) begin
			mismatches++;
			end_sim();
		end
	endtask

	function automatic logic flag(input int sel, input int b);
		case (sel)
			0: flag = bank_idle[b];
			1: flag = bank_active[b];
			2: flag = powered_down;
			default: flag = self_retention;
		endcase
	endfunction

	task automatic poll(input int sel, input int b, input logic exp);
		int i;
		for (i = 0; i < 400; i++) begin
			@(negedge mclk);
			if (flag(sel, b) === exp)
				break;
		end
		check(16'(flag(sel, b)), 16'(exp));
		if (i == 400)
			end_sim();
	endtask

	task automatic t_reset();
		@(negedge mclk);
		check(16'(bank_idle), 16'h0003);
		check(16'(bank_active), 16'h0000);
		check(16'(sdram_link_if_inst.cs_n), 16'h0001);
	endtask

	task automatic t_load();
		issue(C_LOAD, 1'b1, 12'hA50, 16'h0000);
		repeat (6) @(negedge mclk);
		check(16'(mode_word), 16'h0A50);
	endtask

	// Read behind the close finds the row closing; the close waits out row-active time
	task automatic t_open_close();
		base = illegals;
		refused = 1'b0;
		issue(C_OPEN, 1'b1, 12'h000, 16'h0000);
		issue(C_CLOSE, 1'b1, 12'h000, 16'h0000);
		issue(C_READ, 1'b1, 12'h000, 16'h0000);
		@(negedge mclk);
		check(16'(bank_active), 16'h0000);
		repeat (3) issue(C_NOACT, 1'b1, 12'h000, 16'h0000);
		check(16'(refused), 16'h0001);
		poll(0, 0, 1'b1);
		check(16'(illegals - base), 16'h0001);
	endtask

	task automatic t_write_autoclose();
		issue(C_OPEN, 1'b1, 12'h800, 16'h0000);
		poll(1, 1, 1'b1);
		base = illegals;
		issue(C_WRITE, 1'b1, 12'hC00, 16'h5A3C);
		issue(C_OPEN, 1'b1, 12'h800, 16'h0000);
		@(negedge mclk);
		check(16'(bank_idle[1]), 16'h0000);
		poll(0, 1, 1'b1);
		check(last_wr, 16'h5A3C);
		check(16'(illegals - base), 16'h0001);
	endtask

	// A row open during refresh is flagged and dropped
	task automatic t_refresh();
		base = illegals;
		issue(C_REFR, 1'b1, 12'hFFF, 16'hFFFF);
		issue(C_OPEN, 1'b1, 12'h800, 16'h0000);
		repeat (4) @(negedge mclk);
		poll(0, 0, 1'b1);
		check(16'(bank_idle), 16'h0003);
		check(16'(mode_word), 16'h0A50);
		check(16'(illegals - base), 16'h0001);
	endtask

	// Full-page write cut short by a burst halt
	task automatic t_halt();
		repeat (4) @(negedge mclk);
		issue(C_LOAD, 1'b1, 12'h007, 16'h0000);
		repeat (4) @(negedge mclk);
		check(16'(mode_word), 16'h0007);
		issue(C_OPEN, 1'b1, 12'h000, 16'h0000);
		poll(1, 0, 1'b1);
		issue(C_WRITE, 1'b1, 12'h000, 16'hC3A5);
		issue(C_HALT, 1'b1, 12'h000, 16'h0000);
		repeat (3) @(negedge mclk);
		check(16'(bank_active[0]), 16'h0001);
	endtask

	task automatic t_low_power(input logic [3:0] entry, input int sel);
		issue(entry, 1'b0, 12'h000, 16'h0000);
		poll(sel, 0, 1'b1);
		issue(C_LOAD, 1'b0, 12'h123, 16'h0000);
		repeat (4) @(negedge mclk);
		check(16'(mode_word), 16'h0A50);
		issue(C_UNSEL, 1'b1, 12'h000, 16'h0000);
		poll(sel, 0, 1'b0);
	endtask

	initial begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		t_reset();
		t_load();
		t_open_close();
		t_write_autoclose();
		t_refresh();
		t_low_power(C_UNSEL, 2);
		t_low_power(C_REFR, 3);
		t_halt();
		end_sim();
	end
endmodule
